/* hw/upper_decode_pkg.sv */
package upper_decode_pkg;

   // Widths of the request path and the register bus, and the port and interleave range counts.
   localparam int ADDR_W    = 40;
   localparam int DATA_W    = 32;
   localparam int NUM_PORTS = 6;
   localparam int NUM_IL    = 3;

   // Fixed windows of the region below 4 GB.
   localparam logic [39:0] IOINT_BASE      = 40'h00_FEC0_0000;
   localparam logic [39:0] IOINT_COMP_LAST = 40'h00_FEC7_FFFF;
   localparam logic [39:0] IOINT_PORT_BASE = 40'h00_FEC8_0000;
   localparam logic [39:0] IOINT_PORT_LAST = 40'h00_FEC8_5FFF;
   localparam logic [39:0] IOINT_LAST      = 40'h00_FEC8_FFFF;
   localparam logic [39:0] HSMM_BASE       = 40'h00_FEDA_0000;
   localparam logic [39:0] HSMM_LAST       = 40'h00_FEDB_FFFF;
   localparam logic [39:0] INTD_BASE       = 40'h00_FEE0_0000;
   localparam logic [39:0] INTD_LAST       = 40'h00_FEEF_FFFF;
   localparam logic [39:0] REGION_LAST     = 40'h00_FEFF_FFFF;
   localparam logic [39:0] FW_BASE         = 40'h00_FF00_0000;
   localparam logic [39:0] FOUR_GB         = 40'h01_0000_0000;
   localparam logic [39:0] LSMM_BASE       = 40'h00_000A_0000;
   localparam logic [39:0] LSMM_LAST       = 40'h00_000B_FFFF;
   localparam logic [39:0] XBIOS_LAST      = 40'h00_000F_FFFF;
   localparam logic [39:0] CHIPSET_BASE    = 40'h00_FE00_0000;
   localparam logic [17:0] HSMM_OFS_MASK   = 18'h1_FFFF;

   // Register byte offsets.
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_LOW_MEMORY_TOP    = 8'h04;
   localparam logic [7:0] REG_IL0     = 8'h08;
   localparam logic [7:0] REG_STATUS  = 8'h14;
   localparam logic [7:0] REG_COUNT   = 8'h18;
   localparam logic [7:0] REG_PF0     = 8'h20;
   localparam logic [7:0] REG_PF_END  = 8'h80;
   // Word index within one port's block of four.
   localparam logic [1:0] PF_BASE     = 2'h0;
   localparam logic [1:0] PF_LIMIT    = 2'h1;
   localparam logic [1:0] PF_BASE_UP  = 2'h2;
   localparam logic [1:0] PF_LIMIT_UP = 2'h3;

   // Field positions.
   localparam int CTRL_HSMM_BIT   = 0;
   localparam int CTRL_MIRROR_BIT = 1;
   localparam int IL_BRANCH_BIT   = 16;
   localparam int PF_LOW_LSB      = 4;

   // Reset values.
   localparam logic [11:0] LOW_MEMORY_TOP_RST     = 12'h800;
   localparam logic [11:0] IL_RST       = 12'h000;
   localparam logic [11:0] PF_BASE_RST  = 12'hFFF;
   localparam logic [11:0] PF_LIMIT_RST = 12'h000;
   localparam logic [7:0]  PF_UP_RST    = 8'h00;

   // Destination of a decoded request.
   typedef enum logic [3:0] {
      TGT_COMPAT  = 4'h1,
      TGT_PCIE    = 4'h2,
      TGT_MEMORY  = 4'h4,
      TGT_CPU_INT = 4'h8
   } target_e;

   // Kind of request.
   typedef enum logic [2:0] {
      KIND_READ  = 3'h0,
      KIND_WRITE = 3'h1,
      KIND_EWB   = 3'h2,
      KIND_IWB   = 3'h3,
      KIND_INTR  = 3'h4
   } kind_e;

endpackage

/* hw/upper_address_decode.sv */
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module upper_address_decode
   import upper_decode_pkg::*;
(
   // Clock and reset.
   input  wire logic               clk,
   input  wire logic               srst,
   // Register bus.
   input  wire logic [7:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [DATA_W-1:0]  avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [DATA_W-1:0]  avs_readdata,
   output logic                    avs_waitrequest,
   // Request in.
   input  wire logic               req_valid,
   input  wire logic [ADDR_W-1:0]  req_addr,
   input  wire logic [2:0]         req_kind,
   input  wire logic               req_inbound,
   // SMM qualifier pin, active low.
   input  wire logic               smm_memory_qualifier_n,
   // Decision out.
   output logic                    rsp_valid,
   output logic      [3:0]         rsp_target,
   output logic      [2:0]         rsp_port,
   output logic      [ADDR_W-1:0]  rsp_addr,
   output logic                    rsp_master_abort,
   output logic                    rsp_coherent,
   output logic      [1:0]         rsp_branch,
   output logic      [1:0]         rsp_interleave
);

   ////////////////////////////////////////////////////////////////////////
   // Storage.

   logic                high_smm_enable;
   logic                mirror_active;
   logic [11:0]         low_memory_top;
   logic [11:0]         interleave_limit [NUM_IL];
   logic                il_branch        [NUM_IL];
   logic [11:0]         prefetch_base        [NUM_PORTS];
   logic [11:0]         prefetch_limit       [NUM_PORTS];
   logic [7:0]          prefetch_base_upper  [NUM_PORTS];
   logic [7:0]          prefetch_limit_upper [NUM_PORTS];
   logic [15:0]         abort_count;
   logic                ack;
   logic                smm_q_meta;
   logic                smm_q_sync;

   ////////////////////////////////////////////////////////////////////////
   // Qualifier pin synchroniser.

   // Two stages; only the second stage is looked at.
   always_ff @(posedge clk) begin
      if (srst) begin
         smm_q_meta <= 1'b1;
         smm_q_sync <= 1'b1;
      end else begin
         smm_q_meta <= smm_memory_qualifier_n;
         smm_q_sync <= smm_q_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle on every access.

   logic acc;
   logic wr_take;
   assign acc             = (avs_read | avs_write) & ~ack;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_take         = avs_write & ack;

   // Ack pulses for one cycle after a request shows up.
   always_ff @(posedge clk) begin
      if (srst) begin
         ack <= 1'b0;
      end else begin
         ack <= acc;
      end
   end

   // Byte-lane merge of a write into the old register image.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Port block decode of the bus address.
   logic       pf_sel;
   logic [2:0] pf_idx;
   logic [1:0] pf_word;
   logic [7:0] pf_ofs;
   assign pf_sel  = (avs_address >= REG_PF0) && (avs_address < REG_PF_END);
   assign pf_ofs  = avs_address - REG_PF0;
   assign pf_idx  = pf_ofs[6:4];
   assign pf_word = pf_ofs[3:2];

   ////////////////////////////////////////////////////////////////////////
   // Register writes. Writes to unmapped offsets are dropped.

   logic [31:0] ctrl_img;
   logic [31:0] wdat;
   assign ctrl_img = {30'h0, mirror_active, high_smm_enable};

   always_ff @(posedge clk) begin
      if (srst) begin
         high_smm_enable <= 1'b0;
         mirror_active   <= 1'b0;
         low_memory_top  <= LOW_MEMORY_TOP_RST;
         for (int i = 0; i < NUM_IL; i++) begin
            interleave_limit[i] <= IL_RST;
            il_branch[i]        <= 1'b0;
         end
         for (int p = 0; p < NUM_PORTS; p++) begin
            prefetch_base[p]        <= PF_BASE_RST;
            prefetch_limit[p]       <= PF_LIMIT_RST;
            prefetch_base_upper[p]  <= PF_UP_RST;
            prefetch_limit_upper[p] <= PF_UP_RST;
         end
      end else if (wr_take) begin
         if (avs_address == REG_CTRL) begin
            high_smm_enable <= wdat[CTRL_HSMM_BIT];
            mirror_active   <= wdat[CTRL_MIRROR_BIT];
         end
         if (avs_address == REG_LOW_MEMORY_TOP) begin
            low_memory_top <= wdat[11:0];
         end
         for (int i = 0; i < NUM_IL; i++) begin
            if (avs_address == REG_IL0 + 8'(4 * i)) begin
               interleave_limit[i] <= wdat[11:0];
               il_branch[i]        <= wdat[IL_BRANCH_BIT];
            end
         end
         if (pf_sel && pf_idx < 3'(NUM_PORTS)) begin
            case (pf_word)
               PF_BASE: begin
                  prefetch_base[pf_idx] <= wdat[PF_LOW_LSB +: 12];
               end
               PF_LIMIT: begin
                  prefetch_limit[pf_idx] <= wdat[PF_LOW_LSB +: 12];
               end
               PF_BASE_UP: begin
                  prefetch_base_upper[pf_idx] <= wdat[7:0];
               end
               default: begin
                  prefetch_limit_upper[pf_idx] <= wdat[7:0];
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads, registered so data stands when waitrequest drops.

   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0;
      case (avs_address)
         REG_CTRL:   next_rdata = ctrl_img;
         REG_LOW_MEMORY_TOP:   next_rdata = {20'h0, low_memory_top};
         REG_STATUS: next_rdata = {15'h0, rsp_coherent, rsp_master_abort, rsp_port,
                                   rsp_branch, rsp_interleave, rsp_target, 3'h0, ~smm_q_sync};
         REG_COUNT:  next_rdata = {16'h0, abort_count};
         default:    next_rdata = 32'h0;
      endcase
      for (int i = 0; i < NUM_IL; i++) begin
         if (avs_address == REG_IL0 + 8'(4 * i)) begin
            next_rdata = {15'h0, il_branch[i], 4'h0, interleave_limit[i]};
         end
      end
      if (pf_sel && pf_idx < 3'(NUM_PORTS)) begin
         case (pf_word)
            PF_BASE:    next_rdata = {16'h0, prefetch_base[pf_idx], 4'h0};
            PF_LIMIT:   next_rdata = {16'h0, prefetch_limit[pf_idx], 4'h0};
            PF_BASE_UP: next_rdata = {24'h0, prefetch_base_upper[pf_idx]};
            default:    next_rdata = {24'h0, prefetch_limit_upper[pf_idx]};
         endcase
      end
   end

   // The read image doubles as the old value for a byte-lane write merge.
   assign wdat = merge(next_rdata, avs_writedata, avs_byteenable);

   // Read data is caught on the first request cycle.
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_readdata <= 32'h0;
      end else if (acc && avs_read) begin
         avs_readdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // High MMIO window match, one per port.

   logic [NUM_PORTS-1:0] hi_hit;
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         logic        in_high;
         logic [39:0] w_base;
         logic [39:0] w_last;
         // A nonzero upper half moves the window above 4 GB.
         assign in_high = (prefetch_base_upper[gp] != 8'h00) ||
                          (prefetch_limit_upper[gp] != 8'h00);
         assign w_base  = {prefetch_base_upper[gp], prefetch_base[gp], 20'h0_0000};
         assign w_last  = {prefetch_limit_upper[gp], prefetch_limit[gp], 20'hF_FFFF};
         assign hi_hit[gp] = in_high && req_addr >= w_base && req_addr <= w_last;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Decode. Fixed regions are tested first; memory is the fall-through.

   logic [39:0] mem_top;
   logic [39:0] low_memory_top_addr;
   logic        is_write;
   logic        smm_ok;
   assign mem_top   = {interleave_limit[NUM_IL-1], 28'h000_0000};
   assign low_memory_top_addr = {8'h00, low_memory_top, 20'h0_0000};
   assign is_write  = (req_kind == KIND_WRITE) || (req_kind == KIND_EWB) || (req_kind == KIND_IWB);
   // Writebacks must land even without the qualifier, or cached SMM data is lost.
   assign smm_ok    = ~smm_q_sync || req_kind == KIND_EWB || req_kind == KIND_IWB;

   logic [3:0]  next_target;
   logic [2:0]  next_port;
   logic [39:0] next_addr;
   logic        next_abort;
   logic        next_memory;
   logic        next_exempt;

   always_comb begin
      next_target = TGT_COMPAT;
      next_port   = 3'h0;
      next_addr   = req_addr;
      next_abort  = 1'b0;
      next_memory = 1'b0;
      next_exempt = 1'b0;
      if (req_addr >= FW_BASE && req_addr < FOUR_GB) begin
         next_target = TGT_COMPAT;
      end else if (req_addr >= IOINT_BASE && req_addr <= IOINT_COMP_LAST) begin
         next_target = TGT_COMPAT;
      end else if (req_addr >= IOINT_PORT_BASE && req_addr <= IOINT_PORT_LAST) begin
         next_target = TGT_PCIE;
         next_port   = req_addr[14:12];
      end else if (req_addr >= IOINT_PORT_BASE && req_addr <= IOINT_LAST) begin
         next_abort  = 1'b1;
      end else if (req_addr >= HSMM_BASE && req_addr <= HSMM_LAST) begin
         if (high_smm_enable && smm_ok && !req_inbound) begin
            next_memory = 1'b1;
            next_exempt = 1'b1;
            next_addr   = LSMM_BASE | {22'h0, req_addr[17:0] & HSMM_OFS_MASK};
         end else begin
            next_abort  = 1'b1;
         end
      end else if (req_addr >= INTD_BASE && req_addr <= INTD_LAST) begin
         if (!req_inbound && req_kind == KIND_INTR) begin
            next_target = TGT_CPU_INT;
         end else if (req_inbound && req_kind == KIND_WRITE) begin
            next_target = TGT_CPU_INT;
         end else begin
            next_abort  = 1'b1;
         end
      end else if (req_addr >= IOINT_BASE && req_addr <= REGION_LAST) begin
         next_abort  = 1'b1;
      end else if (req_addr >= low_memory_top_addr && req_addr < FOUR_GB) begin
         // Low MMIO and chipset space; the DRAM underneath is lost.
         next_target = TGT_COMPAT;
         next_abort  = req_addr >= CHIPSET_BASE;
      end else if (req_addr >= FOUR_GB && req_addr >= mem_top) begin
         next_abort  = 1'b1;
         for (int p = NUM_PORTS - 1; p >= 0; p--) begin
            if (hi_hit[p]) begin
               next_target = TGT_PCIE;
               next_port   = 3'(p);
               next_abort  = 1'b0;
            end
         end
      end else if (req_addr >= LSMM_BASE && req_addr <= LSMM_LAST) begin
         // The low alias closes while the high window is on.
         if (!high_smm_enable && !smm_q_sync && !req_inbound) begin
            next_memory = 1'b1;
         end else begin
            next_target = TGT_COMPAT;
         end
         next_exempt = 1'b1;
      end else begin
         next_memory = 1'b1;
         next_exempt = req_addr > LSMM_LAST && req_addr <= XBIOS_LAST;
      end
      if (next_memory) begin
         next_target = TGT_MEMORY;
      end
   end

   // Interleave range select: first limit above the address wins.
   logic [1:0] next_il;
   logic       next_il_hit;
   always_comb begin
      next_il     = 2'h0;
      next_il_hit = 1'b0;
      for (int i = NUM_IL - 1; i >= 0; i--) begin
         if (next_addr[39:28] < interleave_limit[i]) begin
            next_il     = 2'(i);
            next_il_hit = 1'b1;
         end
      end
   end

   logic [1:0] next_branch;
   always_comb begin
      next_branch = 2'b00;
      if (next_memory) begin
         next_branch = il_branch[next_il] ? 2'b10 : 2'b01;
         if (mirror_active && is_write) begin
            next_branch = 2'b11;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered decision, one cycle after the request.

   always_ff @(posedge clk) begin
      if (srst) begin
         rsp_valid        <= 1'b0;
         rsp_target       <= TGT_COMPAT;
         rsp_port         <= 3'h0;
         rsp_addr         <= 40'h0;
         rsp_master_abort <= 1'b0;
         rsp_coherent     <= 1'b0;
         rsp_branch       <= 2'b00;
         rsp_interleave   <= 2'h0;
      end else begin
         rsp_valid <= req_valid;
         if (req_valid) begin
            rsp_target       <= next_target;
            rsp_port         <= next_port;
            rsp_addr         <= next_addr;
            rsp_master_abort <= next_abort;
            rsp_coherent     <= next_memory && !next_exempt;
            rsp_branch       <= next_branch;
            rsp_interleave   <= next_il_hit ? next_il : 2'h0;
         end
      end
   end

   // Count of aborted requests, saturating so it never wraps to zero.
   always_ff @(posedge clk) begin
      if (srst) begin
         abort_count <= 16'h0000;
      end else if (req_valid && next_abort && abort_count != 16'hFFFF) begin
         abort_count <= abort_count + 16'h0001;
      end
   end

endmodule // upper_address_decode
`default_nettype wire

/* tb/upper_decode_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module upper_decode_checker
   import upper_decode_pkg::*;
(
   // Clock and reset.
   input wire logic              clk,
   input wire logic              srst,
   // Request in.
   input wire logic              req_valid,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [2:0]        req_kind,
   input wire logic              req_inbound,
   // Decision out.
   input wire logic              rsp_valid,
   input wire logic [3:0]        rsp_target,
   input wire logic [2:0]        rsp_port,
   input wire logic [ADDR_W-1:0] rsp_addr,
   input wire logic              rsp_master_abort,
   input wire logic              rsp_coherent
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////
   // A processor request whose address lies inside one window.
   sequence cpu_req(logic [39:0] lo, logic [39:0] hi);
      req_valid && !req_inbound && req_addr >= lo && req_addr <= hi;
   endsequence
   // Every request gets its decision one cycle after it.
   resp_latency_a : assert property (req_valid |=> rsp_valid) else $error("no decision");
   ioint_compat_a : assert property (cpu_req(IOINT_BASE, IOINT_COMP_LAST) |=> rsp_target == TGT_COMPAT
      && !rsp_master_abort) else $error("first window not to compat link");
   ioint_port_a : assert property (req_valid && req_addr >= IOINT_PORT_BASE
      && req_addr <= IOINT_PORT_LAST |=> rsp_target == TGT_PCIE && rsp_port == $past(req_addr[14:12]))
      else $error("wrong port window");
   ioint_rsvd_a : assert property (cpu_req(IOINT_PORT_LAST + 1, IOINT_LAST) |=> rsp_master_abort)
      else $error("reserved window not aborted");
   fw_compat_a : assert property (cpu_req(FW_BASE, FOUR_GB - 1) |=> rsp_target == TGT_COMPAT)
      else $error("firmware range misrouted");
   // The alias of the high window is the only way to memory from the hole.
   hole_no_mem_a : assert property (req_valid && req_addr >= CHIPSET_BASE && req_addr < FOUR_GB
      && (req_addr < HSMM_BASE || req_addr > HSMM_LAST) |=> rsp_target != TGT_MEMORY) else $error("hole hit memory");
   intd_illegal_a : assert property (cpu_req(INTD_BASE, INTD_LAST) ##0 req_kind <= KIND_WRITE
      |=> rsp_master_abort) else $error("interrupt window access not aborted");
   abort_compat_a : assert property (rsp_valid && rsp_master_abort |-> rsp_target == TGT_COMPAT)
      else $error("abort not on compat link");
   mem_coherence_a : assert property (rsp_valid && rsp_target == TGT_MEMORY
      |-> rsp_coherent == !(rsp_addr >= LSMM_BASE && rsp_addr <= XBIOS_LAST)) else $error("coherency wrong");
   hsmm_alias_a : assert property (cpu_req(HSMM_BASE, HSMM_LAST) |=> rsp_target != TGT_MEMORY
      || rsp_addr == LSMM_BASE + $past(req_addr[16:0])) else $error("alias address wrong");
endmodule // upper_decode_checker
bind upper_address_decode upper_decode_checker u_upper_decode_checker (.clk(clk), .srst(srst),
   .req_valid(req_valid), .req_addr(req_addr), .req_kind(req_kind), .req_inbound(req_inbound),
   .rsp_valid(rsp_valid), .rsp_target(rsp_target), .rsp_port(rsp_port), .rsp_addr(rsp_addr),
   .rsp_master_abort(rsp_master_abort), .rsp_coherent(rsp_coherent));
`default_nettype wire

/* tb/request_source.sv */
`timescale 1ns/100ps
`default_nettype none
module request_source
   import upper_decode_pkg::*;
(
   // Clock.
   input  wire logic              clk,
   // Request out.
   output logic                   req_valid,
   output logic [ADDR_W-1:0]      req_addr,
   output logic [2:0]             req_kind,
   output logic                   req_inbound
);
   // Quiet at start.
   initial begin
      req_valid = 1'b0;
      req_addr = 40'h00_0000_0000;
      req_kind = 3'h0;
      req_inbound = 1'b0;
   end
   // One request per call, so calls in a row give back-to-back requests.
   task automatic issue(input logic [39:0] a, input logic [2:0] k, input logic inb);
      @(posedge clk);
      req_valid <= 1'b1;
      req_addr <= a;
      req_kind <= k;
      req_inbound <= inb;
   endtask
   // Idle address lines are scrambled so a stale value never looks valid.
   task automatic idle();
      @(posedge clk);
      req_valid <= 1'b0;
      req_addr <= ~req_addr;
   endtask
endmodule // request_source
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
   import upper_decode_pkg::*;
;
   logic        clk, srst, avs_read, avs_write, avs_waitrequest, req_valid, req_inbound, qual_n;
   logic        rsp_valid, rsp_master_abort, rsp_coherent;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [39:0] req_addr, rsp_addr;
   logic [3:0]  rsp_target;
   logic [2:0]  req_kind, rsp_port;
   logic [1:0]  rsp_branch, rsp_interleave;
   logic [52:0] e_mon, s_mon;
   logic [52:0] exp_q[$];
   logic [11:0] m_low_memory_top, lim[3];
   bit          br[3];
   bit          m_hsmm, m_mir, m_qact;
   int          n_fail, n_checks, n_abort;
   ////////////////////////////////////////////////////////////////////////////
   upper_address_decode u_upper_address_decode (.clk(clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
      .req_addr(req_addr), .req_kind(req_kind), .req_inbound(req_inbound), .smm_memory_qualifier_n(qual_n),
      .rsp_valid(rsp_valid), .rsp_target(rsp_target), .rsp_port(rsp_port), .rsp_addr(rsp_addr),
      .rsp_master_abort(rsp_master_abort), .rsp_coherent(rsp_coherent), .rsp_branch(rsp_branch),
      .rsp_interleave(rsp_interleave));
   request_source u_request_source (.clk(clk), .req_valid(req_valid), .req_addr(req_addr),
      .req_kind(req_kind), .req_inbound(req_inbound));
   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Reference decode: {target, port, abort, coherent, interleave, address, branch}.
   function automatic logic [52:0] predict(logic [39:0] a, int k, bit inb);
      logic [3:0] t;
      logic [2:0] p;
      bit         ab;
      int         i;
      t = 4'h1;
      p = 3'h0;
      ab = 0;
      i = 0;
      if (a >= FW_BASE && a < FOUR_GB || a >= IOINT_BASE && a <= IOINT_COMP_LAST) t = 4'h1;
      else if (a >= IOINT_PORT_BASE && a <= IOINT_PORT_LAST) begin
         t = 4'h2;
         p = a[14:12];
      end else if (a >= HSMM_BASE && a <= HSMM_LAST && m_hsmm && !inb && (m_qact || k == 2 || k == 3)) begin
         t = 4'h4;
         a = LSMM_BASE + a[16:0];
      end else if (a >= INTD_BASE && a <= INTD_LAST && (k == 4 && !inb || inb && k == 1)) t = 4'h8;
      else if (a >= IOINT_BASE && a <= REGION_LAST) ab = 1;
      else if (a >= {m_low_memory_top, 20'h0_0000} && a < FOUR_GB) ab = a >= CHIPSET_BASE;
      else if (a >= FOUR_GB && a[39:28] >= lim[2]) begin
         if (a >= 40'h20_1000_0000 && a <= 40'h20_1FFF_FFFF) begin
            t = 4'h2;
            p = 3'h2;
         end else ab = 1;
      end else if (a < LSMM_BASE || a > LSMM_LAST || !m_hsmm && m_qact && !inb) begin
         t = 4'h4;
         while (i < 2 && a[39:28] >= lim[i]) i++;
      end
      if (t != 4'h4) return {t, p, ab, 43'h0, 2'h0};
      return {t, p, ab, a > XBIOS_LAST || a < LSMM_BASE, i[1:0], a,
              (m_mir && k >= 1 && k <= 3) ? 2'h3 : (br[i] ? 2'h2 : 2'h1)};
   endfunction
   // Compare one value and count it.
   task automatic chk(string what, logic [52:0] seen, logic [52:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run.
   task automatic finish_test();
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // One register access; the wait is bounded so a stuck slave cannot hang the run.
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge clk);
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i >= 20) begin
         n_fail++;
         finish_test();
      end
   endtask
   // Decisions are read mid-cycle, where they have settled; fields a target leaves open are masked.
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         e_mon = exp_q.pop_front();
         s_mon = {rsp_target, rsp_port & {3{e_mon[52:49] == 4'h2}}, rsp_master_abort,
                  e_mon[52:49] == 4'h4 ? {rsp_coherent, rsp_interleave, rsp_addr} : 43'h0, rsp_branch};
         chk("route", s_mon[52:45], e_mon[52:45]);
         chk("memory", s_mon[44:0], e_mon[44:0]);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Reset, register set-up, then random traffic over every mode combination.
   initial begin
      logic [31:0] q;
      logic [39:0] a;
      int          r, k;
      bit          inb;
      static longint unsigned base[11] = '{64'h0, 64'hA_0000, 64'hC_0000, 64'hFEC0_0000, 64'hFEDA_0000,
         64'hFEE0_0000, 64'hFEC9_0000, 64'hFF00_0000, 64'hB000_0000, 64'h1_0000_0000, 64'h20_0FF0_0000};
      static longint unsigned span[11] = '{64'hA_0000, 64'h2_0000, 64'h4_0000, 64'h9_0000, 64'h2_0000,
         64'h10_0000, 64'h77_0000, 64'h100_0000, 64'h5000_0000, 64'h4_0000_0000, 64'h1_2000_0000};
      static logic [7:0]  cfg_a[8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h40, 8'h44, 8'h48, 8'h4C};
      static logic [31:0] cfg_d[8] = '{32'hC00, 32'h10, 32'h1_0020, 32'h30, 32'h1000, 32'h1FF0, 32'h20, 32'h20};
      void'($urandom(19540));
      srst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      qual_n = 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk("reset", {rsp_valid, rsp_target}, 53'h1);
      bus(1'b0, 8'h04, 32'h0, q);
      chk("low_memory_top", q, 53'h800);
      bus(1'b0, 8'h40, 32'h0, q);
      chk("prefetch_base", q, 53'hFFF0);
      bus(1'b1, 8'h84, 32'hFFFF_FFFF, q);
      bus(1'b0, 8'h84, 32'h0, q);
      chk("unmapped", q, 53'h0);
      for (int j = 0; j < 8; j++) bus(1'b1, cfg_a[j], cfg_d[j], q);
      m_low_memory_top = 12'hC00;
      lim = '{12'h010, 12'h020, 12'h030};
      br = '{0, 1, 0};
      for (int c = 0; c < 8; c++) begin
         m_hsmm = c[0];
         m_mir = c[1];
         m_qact = c[2];
         bus(1'b1, 8'h00, {30'h0, c[1:0]}, q);
         qual_n <= !c[2];
         repeat (4) @(posedge clk);
         for (int n = 0; n < 60; n++) begin
            r = $urandom % 11;
            a = 40'(base[r] + {$urandom, $urandom} % span[r]);
            k = $urandom % 5;
            inb = 1'($urandom % 2);
            u_request_source.issue(a, k[2:0], inb);
            exp_q.push_back(predict(a, k, inb));
            n_abort += exp_q[$][45];
         end
         u_request_source.idle();
         repeat (3) @(posedge clk);
      end
      bus(1'b0, 8'h18, 32'h0, q);
      chk("abort_count", q, 53'(n_abort));
      chk("pending", 53'(exp_q.size()), 53'h0);
      finish_test();
   end
endmodule // testbench
`default_nettype wire
